// *** src/swgp_pkg.sv ***
// shared constants and carrier types of the switch gpio port
package swgp_pkg;
	localparam int PIN_COUNT = 8;
	// register selects on the configuration access port
	localparam logic [1:0] REG_FUNC_SEL = 2'h0;
	localparam logic [1:0] REG_DIR_CFG = 2'h1;
	localparam logic [1:0] REG_PIN_DATA = 2'h2;
	// values after reset
	localparam logic [7:0] FUNC_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// alternate function pin positions
	localparam int PIN_RST_A = 0;
	localparam int PIN_RST_B = 1;
	localparam int PIN_IRQ0 = 2;
	localparam int PIN_IRQ2 = 4;
	localparam int PIN_EVENT = 7;
	localparam logic [7:0] ALT_OUT_MASK = 8'h83;
	// input sampling interval: a least time, so rounded up
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_INTERVAL_NS = 128;
	localparam int SAMPLE_CYCLES = (SAMPLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SAMPLE_RELOAD = 2'(SAMPLE_CYCLES - 1);

	// one configuration access
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [1:0] addr;
		logic [7:0] wrData;
	} swgp_cfg_req_s;

	// values the on-chip alternate functions want on their output pins
	typedef struct packed {
		logic rstA_n;
		logic rstB_n;
		logic event_n;
	} swgp_alt_drive_s;
endpackage

// *** src/swgp_pin_sampler.sv ***
// two-stage synchroniser and periodic sampler for the gpio pin levels
`timescale 1ns/10ps
`default_nettype none
module swgp_pin_sampler import swgp_pkg::*; (
	input wire logic core_clk, // core clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [7:0] pinIn, // raw pin levels
	output logic [7:0] sampled // sampled pin levels
);
	logic [7:0] sync1_q, sync1_d;
	logic [7:0] sync2_q, sync2_d;
	logic [7:0] sample_q, sample_d;
	logic [1:0] cnt_q, cnt_d;

	// synchronise, then take a sample once per interval
	always_comb begin
		sync1_d = pinIn; // [R05]
		sync2_d = sync1_q; // [R05]
		sample_d = sample_q;
		cnt_d = cnt_q - 2'h1;
		if (cnt_q == 2'h0) begin
			cnt_d = SAMPLE_RELOAD; // [R05]
			sample_d = sync2_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			sample_q <= 8'h00;
			cnt_q <= 2'h0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sample_q <= sample_d;
			cnt_q <= cnt_d;
		end
	end

	assign sampled = sample_q;
endmodule
`default_nettype wire

// *** src/swgp_gpio_port.sv ***
// eight-pin gpio port with function, direction and data registers
`timescale 1ns/10ps
`default_nettype none
// Operation
// (R01) eight pins, each set on its own as input, output or alternate function.
// (R02) function bit 1 picks the alternate function, else direction 0 is input and 1 is output.
// (R03) pin 0 and 1 drive downstream resets, pins 2 and 4 take expander interrupts, pin 7 drives the event.
// (R04) reset clears function select and direction so every pin is a plain input.
// (R05) pins are synchronised and sampled no more often than every 128 ns.
// (R06) a pin in plain function holds its alternate function inactive.
// (R07) a plain input pin has its sampled level captured into its data bit.
// (R08) a data read returns the sampled level of every pin in any function.
// (R09) a plain output pin drives the value held in its data bit.
// (R10) a pin with function select set is handled wholly by its alternate logic.
// (R11) a register write reaches the pin by the next clock after the write.
module swgp_gpio_port import swgp_pkg::*; (
	input wire logic core_clk, // core clock
	input wire logic sys_rst, // synchronous reset, high
	input wire swgp_cfg_req_s cfgReq, // register access
	output logic [7:0] cfgRdData, // read data
	output logic cfgRdValid, // read data valid pulse
	input wire logic [7:0] gpioIn, // pin input levels
	output logic [7:0] gpioOut, // pin output levels
	output logic [7:0] gpioOe, // pin output enables
	input wire swgp_alt_drive_s altDrive, // alternate output sources
	output logic expanderIrq0_n, // expander interrupt 0 to core
	output logic expanderIrq2_n // expander interrupt 2 to core
);
	logic [7:0] funcSel_q, funcSel_d;
	logic [7:0] dirCfg_q, dirCfg_d;
	logic [7:0] dataOut_q, dataOut_d;
	logic [7:0] rdData_q, rdData_d;
	logic rdValid_q, rdValid_d;
	logic [7:0] pinOut_q, pinOut_d;
	logic [7:0] pinOe_q, pinOe_d;
	logic irq0_q, irq0_d;
	logic irq2_q, irq2_d;
	logic [7:0] sampled;
	logic [7:0] altValue;
	logic [7:0] altPins;
	logic [7:0] plainOutPins;
	logic [7:0] rdMux;
	logic wrFunc;
	logic wrDir;
	logic wrDrive;

	// register select decode, shared by read and write paths
	function automatic logic hit(input swgp_cfg_req_s req, input logic [1:0] sel);
		hit = (req.addr == sel);
	endfunction

	// a set function bit hands the pin over whatever its direction bit says
	function automatic logic isAlt(input logic [7:0] fSel, input int pin);
		isAlt = fSel[pin];
	endfunction

	// a pin drives its data bit only with function clear and direction set
	function automatic logic isPlainOut(input logic [7:0] fSel, input logic [7:0] dir, input int pin);
		isPlainOut = !fSel[pin] && dir[pin];
	endfunction

	// two-flop synchroniser and interval sampler for the pin levels
	swgp_pin_sampler i_swgp_pin_sampler (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pinIn(gpioIn),
		.sampled(sampled)
	);

	// alternate output sources placed at their pin positions
	always_comb begin
		altValue = 8'h00;
		altValue[PIN_RST_A] = altDrive.rstA_n; // [R03]
		altValue[PIN_RST_B] = altDrive.rstB_n; // [R03]
		altValue[PIN_EVENT] = altDrive.event_n; // [R03]
	end

	// write strobes, one per register; the unmapped select matches none
	always_comb begin
		wrFunc = cfgReq.wrEn && hit(cfgReq, REG_FUNC_SEL);
		wrDir = cfgReq.wrEn && hit(cfgReq, REG_DIR_CFG);
		wrDrive = cfgReq.wrEn && hit(cfgReq, REG_PIN_DATA);
	end

	// function select register
	always_comb begin
		funcSel_d = funcSel_q;
		if (wrFunc) begin
			funcSel_d = cfgReq.wrData; // [R01]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			funcSel_q <= FUNC_RESET; // [R04]
		end else begin
			funcSel_q <= funcSel_d;
		end
	end

	// direction register
	always_comb begin
		dirCfg_d = dirCfg_q;
		if (wrDir) begin
			dirCfg_d = cfgReq.wrData; // [R01]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dirCfg_q <= DIR_RESET; // [R04]
		end else begin
			dirCfg_q <= dirCfg_d;
		end
	end

	// drive value of the data register, only seen on plain output pins
	always_comb begin
		dataOut_d = dataOut_q;
		if (wrDrive) begin
			dataOut_d = cfgReq.wrData; // [R09]
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dataOut_q <= DATA_RESET;
		end else begin
			dataOut_q <= dataOut_d;
		end
	end

	// read select: data reads see the live sampled pins, never the stored drive
	always_comb begin
		rdMux = 8'h00;
		if (hit(cfgReq, REG_FUNC_SEL)) begin
			rdMux = funcSel_q;
		end else if (hit(cfgReq, REG_DIR_CFG)) begin
			rdMux = dirCfg_q;
		end else if (hit(cfgReq, REG_PIN_DATA)) begin
			rdMux = sampled; // [R07] [R08]
		end
	end

	// read port: data holds until the next read, valid pulses once
	always_comb begin
		rdValid_d = cfgReq.rdEn;
		rdData_d = rdData_q;
		if (cfgReq.rdEn) begin
			rdData_d = rdMux;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdData_q <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
		end
	end

	// role of each pin: alternate wins over direction, else direction picks
	always_comb begin
		altPins = 8'h00;
		plainOutPins = 8'h00;
		for (int i = 0; i < PIN_COUNT; i++) begin
			altPins[i] = isAlt(funcSel_q, i); // [R02] [R10]
			plainOutPins[i] = isPlainOut(funcSel_q, dirCfg_q, i); // [R02]
		end
	end

	// per-pin mux between plain output and alternate drive
	always_comb begin
		pinOut_d = 8'h00;
		pinOe_d = 8'h00;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (altPins[i]) begin
				pinOe_d[i] = ALT_OUT_MASK[i]; // [R10]
				pinOut_d[i] = ALT_OUT_MASK[i] & altValue[i]; // [R03] [R10]
			end else if (plainOutPins[i]) begin
				pinOe_d[i] = 1'b1; // [R11]
				pinOut_d[i] = dataOut_q[i]; // [R09] [R11]
			end
		end
	end

	// pins register their drive so the pads see no decode glitches
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pinOut_q <= 8'h00;
			pinOe_q <= 8'h00; // [R04]
		end else begin
			pinOut_q <= pinOut_d;
			pinOe_q <= pinOe_d;
		end
	end

	// interrupt inputs read inactive high unless their pin is handed to them
	always_comb begin
		irq0_d = altPins[PIN_IRQ0] ? sampled[PIN_IRQ0] : 1'b1; // [R03] [R06] [R10]
		irq2_d = altPins[PIN_IRQ2] ? sampled[PIN_IRQ2] : 1'b1; // [R03] [R06] [R10]
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq0_q <= 1'b1;
			irq2_q <= 1'b1;
		end else begin
			irq0_q <= irq0_d;
			irq2_q <= irq2_d;
		end
	end

	// outputs straight from their flip-flops
	assign cfgRdData = rdData_q;
	assign cfgRdValid = rdValid_q;
	assign gpioOut = pinOut_q;
	assign gpioOe = pinOe_q;
	assign expanderIrq0_n = irq0_q;
	assign expanderIrq2_n = irq2_q;
endmodule
`default_nettype wire

// *** verif/swgp_board_model.sv ***
// board around the pins: pull-ups, outside drivers and resolved levels
`timescale 1ns/10ps
`default_nettype none
module swgp_board_model (
	input wire logic [7:0] gpioOut, // device drive levels
	input wire logic [7:0] gpioOe, // device drive enables
	input wire logic [7:0] boardLevel, // board driver or pull-up level
	output logic [7:0] gpioIn // resolved pin levels
);
	// a driven pin shows the device value, a released one the board level
	assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & boardLevel);
endmodule
`default_nettype wire

// *** verif/swgp_gpio_port_assertions.sv ***
// concurrent checks of the gpio port pins and register answers
`timescale 1ns/10ps
`default_nettype none
module swgp_gpio_port_assertions import swgp_pkg::*; (
	input wire logic core_clk, // core clock
	input wire logic sys_rst, // synchronous reset
	input wire swgp_cfg_req_s cfgReq, // register access
	input wire logic [7:0] cfgRdData, // read data
	input wire logic cfgRdValid, // read valid
	input wire logic [7:0] gpioOut, // pin levels out
	input wire logic [7:0] gpioOe, // pin enables
	input wire swgp_alt_drive_s altDrive, // alternate sources
	input wire logic expanderIrq0_n, // irq 0
	input wire logic expanderIrq2_n // irq 2
);
	logic [7:0] fSel_q = 8'h00, dir_q = 8'h00, dat_q = 8'h00;
	logic rstSeen_q = 1'b0;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// mirror of the configuration registers, and whether the last edge was in reset
	always_ff @(posedge core_clk) begin
		rstSeen_q <= sys_rst;
		if (sys_rst) begin
			fSel_q <= 8'h00;
			dir_q <= 8'h00;
			dat_q <= 8'h00;
		end else if (cfgReq.wrEn) begin
			if (cfgReq.addr == REG_FUNC_SEL) fSel_q <= cfgReq.wrData;
			if (cfgReq.addr == REG_DIR_CFG) dir_q <= cfgReq.wrData;
			if (cfgReq.addr == REG_PIN_DATA) dat_q <= cfgReq.wrData;
		end
	end
	// pin state the registers call for
	wire logic [7:0] altVal = {altDrive.event_n, 5'h00, altDrive.rstB_n, altDrive.rstA_n};
	wire logic [7:0] expOe = (fSel_q & ALT_OUT_MASK) | (~fSel_q & dir_q);
	wire logic [7:0] expOut = (fSel_q & ALT_OUT_MASK & altVal) | (~fSel_q & dir_q & dat_q);
	sequence readTaken; cfgReq.rdEn; endsequence
	// expected answer of a register read; data reads are compared by the bench
	wire logic [7:0] expRd = (cfgReq.addr == REG_FUNC_SEL) ? fSel_q : (cfgReq.addr == REG_DIR_CFG) ? dir_q : 8'h00;
	sequence readAnswered; cfgRdValid ##0 ($past(cfgReq.addr) == REG_PIN_DATA || cfgRdData == $past(expRd)); endsequence
	a_read_answer: assert property (readTaken |=> readAnswered)
		else $error("read not answered");
	a_no_stray_valid: assert property (!cfgReq.rdEn |=> !cfgRdValid)
		else $error("stray read valid");
	a_unmapped_zero: assert property (cfgReq.rdEn && cfgReq.addr == 2'h3 |=> cfgRdData == 8'h00)
		else $error("unmapped read not zero");
	a_func_readback: assert property (cfgReq.rdEn && cfgReq.addr == REG_FUNC_SEL |=> cfgRdData == $past(fSel_q))
		else $error("function readback wrong");
	a_oe_follows_cfg: assert property (gpioOe == $past(expOe))
		else $error("pin enable wrong");
	a_out_follows_cfg: assert property (gpioOut == $past(expOut))
		else $error("pin drive wrong");
	a_irq_idle: assert property (!$past(fSel_q[PIN_IRQ0]) |-> expanderIrq0_n)
		else $error("idle irq active");
	a_reset_clear: assert property (disable iff (1'b0) rstSeen_q |-> gpioOe == 8'h00 && expanderIrq2_n)
		else $error("reset state wrong");
endmodule
`default_nettype wire

// *** verif/swgp_gpio_port_tb.sv ***
// self-checking bench of the gpio port against a board model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h", $time, a); end end
module swgp_gpio_port_tb import swgp_pkg::*;;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	swgp_cfg_req_s cfgReq = '0;
	swgp_alt_drive_s altDrive = '0;
	logic [7:0] boardLevel = 8'hFF, gpioIn, gpioOut, gpioOe, cfgRdData;
	logic cfgRdValid, expanderIrq0_n, expanderIrq2_n;
	int failures = 0, compares = 0, cyc = 0;
	initial forever #25 core_clk = ~core_clk;
	swgp_gpio_port i_swgp_gpio_port (.core_clk, .sys_rst, .cfgReq, .cfgRdData, .cfgRdValid, .gpioIn, .gpioOut,
		.gpioOe, .altDrive, .expanderIrq0_n, .expanderIrq2_n);
	swgp_board_model i_swgp_board_model (.gpioOut, .gpioOe, .boardLevel, .gpioIn);
	// one register write
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk) cfgReq <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk) cfgReq <= '0;
	endtask
	// one register read with expected data
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge core_clk) cfgReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk) cfgReq <= '0;
		#1 `CHK(cfgRdValid, 1'b1)
		`CHK(cfgRdData, e)
	endtask
	task automatic results();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(REG_FUNC_SEL, FUNC_RESET);
		rd(REG_DIR_CFG, DIR_RESET);
		rd(2'h3, 8'h00);
		@(posedge core_clk) boardLevel <= 8'hA5;
		repeat (8) @(posedge core_clk);
		rd(REG_PIN_DATA, 8'hA5);
		wr(REG_PIN_DATA, 8'h3C);
		wr(REG_DIR_CFG, 8'hF0);
		@(posedge core_clk) #1 `CHK(gpioOe, 8'hF0)
		`CHK(gpioOut, 8'h30)
		repeat (8) @(posedge core_clk);
		rd(REG_PIN_DATA, 8'h35);
		wr(2'h3, 8'hFF);
		rd(REG_DIR_CFG, 8'hF0);
		@(posedge core_clk) altDrive <= '{1'b0, 1'b1, 1'b0};
		boardLevel <= 8'h00;
		wr(REG_FUNC_SEL, 8'hFF);
		repeat (8) @(posedge core_clk);
		#1 `CHK(gpioOe, ALT_OUT_MASK)
		`CHK(gpioOut, 8'h02)
		`CHK({expanderIrq2_n, expanderIrq0_n}, 2'b00)
		rd(REG_PIN_DATA, 8'h02);
		@(posedge core_clk) altDrive <= '{1'b1, 1'b0, 1'b1};
		@(posedge core_clk) #1 `CHK(gpioOut, 8'h81)
		wr(REG_FUNC_SEL, 8'h00);
		@(posedge core_clk) #1 `CHK({expanderIrq2_n, expanderIrq0_n}, 2'b11)
		`CHK(gpioOe, 8'hF0)
		results();
	end
endmodule
bind swgp_gpio_port swgp_gpio_port_assertions i_swgp_gpio_port_assertions (.core_clk, .sys_rst, .cfgReq,
	.cfgRdData, .cfgRdValid, .gpioOut, .gpioOe, .altDrive, .expanderIrq0_n, .expanderIrq2_n);
`default_nettype wire
